// File: verilog/pmsc_pkg.sv
// Constants for the program mode and stack control block
// Contract
// R1 - Mode flag bit 3 high selects compact mode, low selects extended mode.
// R2 - Fifteen-bit program counter; compact mode forces bit 14 to zero.
// R3 - Usable program addresses end at 3FFFH compact, 7FFFH extended.
// R4 - 32768-byte program store, only 16384 bytes reachable in compact mode.
// R5 - A call pushes two bytes in compact mode, three in extended mode.
// R6 - Long jump and long invoke are allowed only in extended mode.
// R7 - Absolute invoke takes three machine cycles compact, four extended.
// R8 - Fixed-area invoke takes two machine cycles compact, three extended.
// R9 - Reset sets the mode flag so the core starts in compact mode.
// R10 - Software writes 10XXB or 00XXB at start; low bits pick stack bank.
// R11 - Stack area lives in data bank zero to three chosen by low bits.
// R12 - Extended-mode software sets the register before any call or interrupt.
// R13 - Vectored interrupt entry addresses are fourteen bits wide.
// R14 - Page jumps replace only the low eight program counter bits.
// R15 - Data memory holds a 1024 by 4-bit static RAM area.
// R16 - After reset execution waits 2^15 main clock periods, fixed.
// R17 - Returns pop as many bytes as a call pushes in current mode.
// R18 - Mode writes take effect from the next fetch; stacked calls unchanged.
package pmsc_pkg;
  localparam int          PC_W            = 15;
  localparam int          PC_TOP_BIT      = 14;
  localparam int          VEC_W           = 14;
  localparam int          PAGE_W          = 8;
  localparam int          MODE_BIT        = 3;
  localparam logic [3:0]  SBS_RESET       = 4'h8;
  localparam logic [14:0] COMPACT_LIMIT   = 15'h3fff;
  localparam logic [14:0] EXTENDED_LIMIT  = 15'h7fff;
  localparam int          PROM_BYTES      = 32768;
  localparam int          PROM_COMPACT    = 16384;
  localparam logic [1:0]  PUSH_COMPACT    = 2'h2;
  localparam logic [1:0]  PUSH_EXTENDED   = 2'h3;
  localparam logic [2:0]  ABS_CYC_COMPACT = 3'h3;
  localparam logic [2:0]  ABS_CYC_EXT     = 3'h4;
  localparam logic [2:0]  FIX_CYC_COMPACT = 3'h2;
  localparam logic [2:0]  FIX_CYC_EXT     = 3'h3;
  localparam int          RAM_WORDS       = 1024;
  localparam int          RAM_AW          = 10;
  localparam int          RAM_DW          = 4;
  localparam int          WAIT_EXP        = 15;
  localparam int          WAIT_CYCLES     = 32768;
  // Program counter operations
  typedef enum logic [2:0] {
    PMSC_OP_NONE   = 3'b000,
    PMSC_OP_STEP   = 3'b001,
    PMSC_OP_JUMP   = 3'b010,
    PMSC_OP_LONG   = 3'b011,
    PMSC_OP_VECTOR = 3'b100,
    PMSC_OP_PAGE   = 3'b101,
    PMSC_OP_RETURN = 3'b110
  } pmsc_op_t;
  // Reset wait state
  typedef enum logic [0:0] {
    PMSC_WAIT = 1'b0,
    PMSC_RUN  = 1'b1
  } pmsc_state_t;
endpackage : pmsc_pkg

// File: verilog/pmsc_ram.sv
// Data area static RAM with registered read data
`timescale 1ns/1ns
module pmsc_ram #(
  parameter int AW = 10,
  parameter int DW = 4
) (
  input  wire logic          clk_sys,
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output logic      [DW-1:0] rdata
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // Contents are undefined after power-up, as real SRAM
  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule : pmsc_ram

// File: verilog/pmsc_core.sv
// Mode control, program counter, stack sizing and data area
`timescale 1ns/1ns
module pmsc_core #(
  parameter int WAIT_CYCLES = pmsc_pkg::WAIT_CYCLES
) (
  input  wire logic                  clk_sys,
  input  wire logic                  reset_n,
  input  wire logic                  sbs_we,
  input  wire logic [3:0]            sbs_wdata,
  output logic      [3:0]            stack_bank_mode_register,
  input  wire logic                  fetch,
  input  wire pmsc_pkg::pmsc_op_t    pc_op,
  input  wire logic [14:0]           pc_target,
  input  wire logic                  call_start,
  input  wire logic                  call_fixed,
  output logic      [14:0]           pc,
  output logic                       compact_mode,
  output logic                       extended_mode,
  output logic                       long_ops_enabled,
  output logic                       long_op_fault,
  output logic      [14:0]           prog_limit,
  output logic                       addr_in_range,
  output logic      [1:0]            stack_bytes,
  output logic      [1:0]            stack_bank,
  output logic      [2:0]            call_cycles,
  output logic                       run,
  input  wire logic                  ram_we,
  input  wire logic [9:0]            ram_addr,
  input  wire logic [3:0]            ram_wdata,
  output logic      [3:0]            ram_rdata
);
  // Whole block state
  typedef struct packed {
    logic [3:0]            stack_bank_and_mode_select;
    logic                  mode_live;
    logic [14:0]           pc;
    logic                  fault;
    logic [15:0]           wait_cnt;
    pmsc_pkg::pmsc_state_t state;
  } pmsc_regs_t;

  pmsc_regs_t r;
  pmsc_regs_t next_r;
  logic       live_compact;

  // Mode applies from the fetch after the write, never mid-instruction
  assign live_compact      = r.mode_live;
  assign stack_bank_mode_register = r.stack_bank_and_mode_select;
  assign compact_mode      = live_compact;                                   // R1
  assign extended_mode     = !live_compact;                                  // R1
  assign long_ops_enabled  = !live_compact;                                  // R6
  assign prog_limit        = live_compact ? pmsc_pkg::COMPACT_LIMIT
                                          : pmsc_pkg::EXTENDED_LIMIT;        // R3
  assign addr_in_range     = (pc <= prog_limit);                             // R4
  assign stack_bytes       = live_compact ? pmsc_pkg::PUSH_COMPACT
                                          : pmsc_pkg::PUSH_EXTENDED;         // R5 R17
  assign stack_bank        = r.stack_bank_and_mode_select[1:0];                                     // R11
  assign pc                = r.pc;
  assign long_op_fault     = r.fault;
  assign run               = (r.state == pmsc_pkg::PMSC_RUN);

  // Call duration by call kind and mode
  always_comb begin
    if (call_fixed) begin
      call_cycles = live_compact ? pmsc_pkg::FIX_CYC_COMPACT : pmsc_pkg::FIX_CYC_EXT; // R8
    end else begin
      call_cycles = live_compact ? pmsc_pkg::ABS_CYC_COMPACT : pmsc_pkg::ABS_CYC_EXT; // R7
    end
  end

  // Next state: reset wait, register writes and program counter updates
  always_comb begin
    next_r       = r;
    next_r.fault = 1'b0;
    if (sbs_we) begin
      next_r.stack_bank_and_mode_select = sbs_wdata;
    end
    case (r.state)
      pmsc_pkg::PMSC_WAIT: begin
        // Fixed wait, not selectable by software
        if (r.wait_cnt == 16'(WAIT_CYCLES - 1)) begin
          next_r.state = pmsc_pkg::PMSC_RUN;                                 // R16
        end else begin
          next_r.wait_cnt = r.wait_cnt + 16'h0001;                           // R16
        end
      end
      pmsc_pkg::PMSC_RUN: begin
        if (fetch) begin
          next_r.mode_live = r.stack_bank_and_mode_select[pmsc_pkg::MODE_BIT];                      // R18
        end
        case (pc_op)
          pmsc_pkg::PMSC_OP_STEP: begin
            next_r.pc = r.pc + 15'h0001;
          end
          pmsc_pkg::PMSC_OP_JUMP: begin
            next_r.pc = {1'b0, pc_target[13:0]};
          end
          pmsc_pkg::PMSC_OP_LONG: begin
            if (live_compact) begin
              next_r.fault = 1'b1;                                           // R6
            end else begin
              next_r.pc = pc_target;
            end
          end
          pmsc_pkg::PMSC_OP_VECTOR: begin
            next_r.pc = {1'b0, pc_target[13:0]};                             // R13
          end
          pmsc_pkg::PMSC_OP_PAGE: begin
            next_r.pc = {r.pc[14:8], pc_target[7:0]};                        // R14
          end
          pmsc_pkg::PMSC_OP_RETURN: begin
            next_r.pc = pc_target;                                           // R17
          end
          default: begin
            next_r.pc = r.pc;
          end
        endcase
        // Compact mode holds bit 14 at zero, lower bits wrap in 16K
        if (live_compact) begin
          next_r.pc[pmsc_pkg::PC_TOP_BIT] = 1'b0;                            // R2
        end
      end
      default: begin
        next_r.state = pmsc_pkg::PMSC_WAIT;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      r.stack_bank_and_mode_select       <= pmsc_pkg::SBS_RESET;                                    // R9
      r.mode_live <= 1'b1;                                                   // R9
      r.pc        <= 15'h0000;
      r.fault     <= 1'b0;
      r.wait_cnt  <= 16'h0000;
      r.state     <= pmsc_pkg::PMSC_WAIT;
    end else begin
      r <= next_r;
    end
  end

  // Data area
  pmsc_ram #(
    .AW (pmsc_pkg::RAM_AW),
    .DW (pmsc_pkg::RAM_DW)
  ) u_ram (
    .clk_sys (clk_sys),
    .we      (ram_we),
    .addr    (ram_addr),
    .wdata   (ram_wdata),
    .rdata   (ram_rdata)                                                     // R15
  );

  // Checks
  property p_compact_top;
    @(posedge clk_sys) disable iff (!reset_n)
      compact_mode |-> ##1 (pc[14] == 1'b0 || !$past(compact_mode));
  endproperty
  a_compact_top: assert property (p_compact_top) else $error("pc bit 14 set in compact mode"); // R2

  // A fetch taken while running latches the mode bit
  sequence s_fetch_taken;
    run && fetch;
  endsequence

  // Push size follows the register bit seen at the fetch, not the wiring of compact_mode
  property p_push;
    @(posedge clk_sys) disable iff (!reset_n)
      s_fetch_taken |=> stack_bytes == ($past(stack_bank_mode_register[pmsc_pkg::MODE_BIT])
                                         ? pmsc_pkg::PUSH_COMPACT : pmsc_pkg::PUSH_EXTENDED);
  endproperty
  a_push: assert property (p_push) else $error("wrong stack byte count"); // R5

  property p_long_fault;
    @(posedge clk_sys) disable iff (!reset_n)
      (run && compact_mode && pc_op == pmsc_pkg::PMSC_OP_LONG) |=> long_op_fault;
  endproperty
  a_long_fault: assert property (p_long_fault) else $error("long op not refused"); // R6

  property p_abs_cyc;
    @(posedge clk_sys) disable iff (!reset_n)
      !call_fixed |-> call_cycles == (compact_mode ? 3'h3 : 3'h4);
  endproperty
  a_abs_cyc: assert property (p_abs_cyc) else $error("absolute call cycles wrong"); // R7

  property p_fix_cyc;
    @(posedge clk_sys) disable iff (!reset_n)
      call_fixed |-> call_cycles == (compact_mode ? 3'h2 : 3'h3);
  endproperty
  a_fix_cyc: assert property (p_fix_cyc) else $error("fixed call cycles wrong"); // R8

  property p_page;
    @(posedge clk_sys) disable iff (!reset_n)
      (run && pc_op == pmsc_pkg::PMSC_OP_PAGE) |=> pc[14:8] == $past(pc[14:8]);
  endproperty
  a_page: assert property (p_page) else $error("page jump changed upper pc"); // R14

  property p_vector;
    @(posedge clk_sys) disable iff (!reset_n)
      (run && pc_op == pmsc_pkg::PMSC_OP_VECTOR) |=> pc[14] == 1'b0;
  endproperty
  a_vector: assert property (p_vector) else $error("vector above 3FFFH"); // R13

  property p_mode_fetch;
    @(posedge clk_sys) disable iff (!reset_n)
      (run && !fetch) |=> compact_mode == $past(compact_mode);
  endproperty
  a_mode_fetch: assert property (p_mode_fetch) else $error("mode changed without fetch"); // R18

  property p_wait;
    @(posedge clk_sys) disable iff (!reset_n)
      $rose(run) |-> $past(r.wait_cnt) == 16'(WAIT_CYCLES - 1);
  endproperty
  a_wait: assert property (p_wait) else $error("reset wait length wrong"); // R16
endmodule : pmsc_core

// File: testbench/tb.sv
// Self-checking bench for the program mode and stack control block
`timescale 1ns/1ns
module tb;
  typedef struct {int sel; logic [14:0] exp;} pmsc_note_t;
  logic               clk_sys = 1'b0;
  logic               reset_n = 1'b0;
  logic               sbs_we = 1'b0, fetch = 1'b0, call_start = 1'b0, call_fixed = 1'b0, ram_we = 1'b0, cm;
  logic [3:0]         sbs_wdata = 4'h0, ram_wdata = 4'h0, stack_bank_mode_register, ram_rdata;
  pmsc_pkg::pmsc_op_t pc_op = pmsc_pkg::PMSC_OP_NONE;
  logic [14:0]        pc_target = 15'h0000, pc, prog_limit;
  logic [9:0]         ram_addr = 10'h000;
  logic               compact_mode, extended_mode, long_ops_enabled, long_op_fault, addr_in_range, run;
  logic [1:0]         stack_bytes, stack_bank;
  logic [2:0]         call_cycles;
  int                 n_fail = 0, tests_run = 0;
  pmsc_note_t         q[$];
  event               chk;
  string nm[13] = '{"register", "compact", "extended", "long_en", "fault", "limit", "in_range",
                    "stack_bytes", "bank", "cycles", "pc", "ram", "run"};

  pmsc_core #(.WAIT_CYCLES(8)) DUT (.clk_sys, .reset_n, .sbs_we, .sbs_wdata, .stack_bank_mode_register,
    .fetch, .pc_op, .pc_target, .call_start, .call_fixed, .pc, .compact_mode, .extended_mode,
    .long_ops_enabled, .long_op_fault, .prog_limit, .addr_in_range, .stack_bytes, .stack_bank,
    .call_cycles, .run, .ram_we, .ram_addr, .ram_wdata, .ram_rdata);

  // Free-running system clock
  always #5 clk_sys = ~clk_sys;

  function automatic logic [14:0] obs(int s);
    case (s)
      0: obs = 15'(stack_bank_mode_register);
      1: obs = 15'(compact_mode);
      2: obs = 15'(extended_mode);
      3: obs = 15'(long_ops_enabled);
      4: obs = 15'(long_op_fault);
      5: obs = prog_limit;
      6: obs = 15'(addr_in_range);
      7: obs = 15'(stack_bytes);
      8: obs = 15'(stack_bank);
      9: obs = 15'(call_cycles);
      10: obs = pc;
      11: obs = 15'(ram_rdata);
      default: obs = 15'(run);
    endcase
  endfunction : obs

  // Compact mode keeps only the low 14 address bits
  function automatic logic [14:0] msk(logic [14:0] x);
    msk = cm ? {1'b0, x[13:0]} : x;
  endfunction : msk

  // Watcher: drains all queued notes, oldest first, each time the driver says outputs are settled
  always @(chk) begin
    pmsc_note_t n;
    while (q.size() > 0) begin
      n = q.pop_front();
      tests_run++;
      if (obs(n.sel) !== n.exp) begin
        n_fail++;
        $display("wrong value %s expected %h seen %h", nm[n.sel], n.exp, obs(n.sel));
      end
    end
  end

  task automatic note(int s, logic [14:0] e);
    q.push_back(pmsc_note_t'{s, e});
  endtask : note

  // Compare on the falling edge, clear of the launching edge
  task automatic look();
    @(negedge clk_sys);
    -> chk;
    #1;
  endtask : look

  task automatic rst();
    @(posedge clk_sys);
    reset_n <= 1'b0;
    repeat (12) @(posedge clk_sys);
    note(0, 15'h0008);
    note(1, 15'h0001);
    note(12, 15'h0000);
    look();
    @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    note(12, 15'h0000);
    look();
    repeat (8) @(posedge clk_sys);
    note(12, 15'h0001);
    look();
  endtask : rst

  task automatic pcop(pmsc_pkg::pmsc_op_t o, logic [14:0] t, logic [14:0] e, logic f);
    @(posedge clk_sys);
    pc_op      <= o;
    pc_target  <= t;
    call_start <= 1'($urandom);
    @(posedge clk_sys);
    pc_op <= pmsc_pkg::PMSC_OP_NONE;
    note(10, e);
    note(4, 15'(f));
    note(6, 15'h0001);
    look();
  endtask : pcop

  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : conclude

  // Watchdog, far beyond the hundred or so cycles the sequence needs
  initial begin
    repeat (5000) @(posedge clk_sys);
    n_fail++;
    conclude();
  end

  // Main sequence: extended mode first, then back to compact
  initial begin
    logic [3:0]  d;
    logic [14:0] t, p;
    void'($urandom(17));
    rst();
    for (int m = 0; m < 2; m++) begin
      d = {m[0], 3'($urandom)};
      cm = d[3];
      @(posedge clk_sys);
      sbs_we    <= 1'b1;
      sbs_wdata <= d;
      @(posedge clk_sys);
      sbs_we <= 1'b0;
      fetch  <= 1'b0;
      note(0, 15'(d));
      note(8, 15'(d[1:0]));
      note(1, 15'(!m[0]));
      look();
      @(posedge clk_sys);
      fetch <= 1'b1;
      @(posedge clk_sys);
      fetch      <= 1'b0;
      call_fixed <= 1'b1;
      note(1, 15'(cm));
      note(2, 15'(!cm));
      note(3, 15'(!cm));
      note(5, cm ? 15'h3fff : 15'h7fff);
      note(7, cm ? 15'h0002 : 15'h0003);
      note(9, cm ? 15'h0002 : 15'h0003);
      look();
      @(posedge clk_sys);
      call_fixed <= 1'b0;
      note(9, cm ? 15'h0003 : 15'h0004);
      look();
      t = 15'($urandom);
      // Plain jump carries a 14-bit address in both modes
      pcop(pmsc_pkg::PMSC_OP_JUMP, t, {1'b0, t[13:0]}, 1'b0);
      p = cm ? msk(t) : ~t;
      pcop(pmsc_pkg::PMSC_OP_LONG, ~t, p, cm);
      pcop(pmsc_pkg::PMSC_OP_PAGE, t ^ 15'h0055, {p[14:8], t[7:0] ^ 8'h55}, 1'b0);
      pcop(pmsc_pkg::PMSC_OP_VECTOR, t, {1'b0, t[13:0]}, 1'b0);
      pcop(pmsc_pkg::PMSC_OP_JUMP, 15'h7fff, 15'h3fff, 1'b0);
      pcop(pmsc_pkg::PMSC_OP_STEP, t, cm ? 15'h0000 : 15'h4000, 1'b0);
      pcop(pmsc_pkg::PMSC_OP_RETURN, t, msk(t), 1'b0);
    end
    // Data area: write then read back, including the top word
    for (int i = 0; i < 4; i++) begin
      d = 4'($urandom);
      @(posedge clk_sys);
      ram_we    <= 1'b1;
      ram_addr  <= 10'(i * 341);
      ram_wdata <= d;
      @(posedge clk_sys);
      ram_we <= 1'b0;
      @(posedge clk_sys);
      note(11, 15'(d));
      look();
    end
    rst();
    conclude();
  end
endmodule : tb
